// ==== logic/diag_monitor.sv ====
/*
 Diagnostic status, flash memory test and two alarm comparators.
 Assumes a synchronous flash read port with one cycle of latency, a
 sample tick pulse from the sampler, and live condition inputs.
*/
`timescale 1ns/1ps
module diag_monitor
#(
	parameter int FLASH_DEPTH = 512,
	parameter int FLASH_AW = 9
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [diag_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	input wire logic sample_tick_in,
	input wire logic [diag_pkg::N_SRC-1:0][diag_pkg::SRC_W-1:0] raw_data_in,
	input wire logic [diag_pkg::N_SRC-1:0][diag_pkg::SRC_W-1:0] filt_data_in,
	input wire logic supply_high_in,
	input wire logic supply_low_in,
	input wire logic [5:0] selftest_fail_in,
	input wire logic selftest_err_in,
	input wire logic overrange_in,
	input wire logic comm_fail_in,
	input wire logic flash_update_fail_in,
	output logic [FLASH_AW-1:0] flash_addr_out,
	input wire logic [15:0] flash_data_in,
	input wire logic [15:0] flash_checksum_in,
	output logic [15:0] sample_period_out,
	output logic digital_line_one_out,
	output logic digital_line_one_oe_out,
	output logic digital_line_two_out,
	output logic digital_line_two_oe_out
);
	import diag_pkg::*;

	localparam int MT_MAX = 600;

	logic [15:0] diag_r;
	logic [15:0] diag_set;
	logic [15:0] diag_nxt;
	logic [1:0][15:0] thr_r;
	logic [1:0][7:0] cnt_r;
	logic [15:0] alarm_control_reg_r;
	logic [15:0] misc_r;
	logic [15:0] sample_period_reg_r;
	logic [15:0] rdata_r;
	logic rd_diag;
	logic tick_d_r;
	logic [1:0] alm_act;
	logic alm_any;
	memtest_state_type mt_state_r;
	logic [FLASH_AW:0] mt_cnt_r;
	logic mt_valid_r;
	logic [15:0] mt_sum_r;
	logic mt_fail;
	logic mt_done;
	logic line1_r;
	logic line1_oe_r;
	logic line2_r;
	logic line2_oe_r;

	////////////////////////////////////////////////////////////////
	function automatic logic [3:0] src_code(input int ch);
		src_code = alarm_control_reg_r[B_SRC1 + 4 * ch +: 4];
	endfunction

	function automatic logic src_ok(input logic [3:0] code);
		src_ok = (code != 4'h0) && (code <= 4'hb);
	endfunction

	function automatic logic [13:0] src_pick(input logic [3:0] code);
		logic [3:0] idx;
		idx = src_ok(code) ? code - 4'h1 : 4'h0;
		src_pick = alarm_control_reg_r[B_FILT] ? filt_data_in[idx] :
			raw_data_in[idx]; // RQ20
	endfunction

	function automatic logic [7:0] thr_ofs(input int ch);
		thr_ofs = (ch == 0) ? OFS_THR1 : OFS_THR2;
	endfunction

	function automatic logic [7:0] cnt_ofs(input int ch);
		cnt_ofs = (ch == 0) ? OFS_CNT1 : OFS_CNT2;
	endfunction

	////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			thr_r <= '0; // RQ17
			cnt_r <= '0;
		end
		else if (reg_wr_in)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (reg_addr_in == thr_ofs(i))
					thr_r[i] <= reg_wdata_in;
				if (reg_addr_in == cnt_ofs(i))
					cnt_r[i] <= reg_wdata_in[7:0]; // RQ16
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			alarm_control_reg_r <= RST_ZERO;
		else if (reg_wr_in && reg_addr_in == OFS_ALARM_CONTROL_REG)
			alarm_control_reg_r <= reg_wdata_in; // RQ12
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			sample_period_reg_r <= RST_ZERO;
		else if (reg_wr_in && reg_addr_in == OFS_SAMPLE_PERIOD_REG)
			sample_period_reg_r <= reg_wdata_in;
	end

	assign sample_period_out = sample_period_reg_r;

	// a write in the completion cycle wins, so a new test is not lost
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			misc_r <= RST_MISC;
		else if (reg_wr_in && reg_addr_in == OFS_MISC)
			misc_r <= reg_wdata_in & MISC_MASK;
		else if (mt_done)
			misc_r[B_MEMTEST] <= 1'b0; // RQ1
	end

	////////////////////////////////////////////////////////////////
	// flash checksum walk

	assign mt_done = (mt_state_r == MT_DONE);
	assign mt_fail = mt_done && (mt_sum_r != flash_checksum_in); // RQ2
	assign flash_addr_out = mt_cnt_r[FLASH_AW-1:0];

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mt_state_r <= MT_IDLE;
			mt_cnt_r <= '0;
			mt_valid_r <= 1'b0;
			mt_sum_r <= 16'h0000;
		end
		else
		begin
			unique case (mt_state_r)
				MT_IDLE:
				begin
					mt_cnt_r <= '0;
					mt_valid_r <= 1'b0;
					mt_sum_r <= 16'h0000;
					if (misc_r[B_MEMTEST])
						mt_state_r <= MT_RUN; // RQ1
				end
				MT_RUN:
				begin
					mt_valid_r <= (mt_cnt_r < FLASH_DEPTH[FLASH_AW:0]);
					if (mt_cnt_r < FLASH_DEPTH[FLASH_AW:0])
						mt_cnt_r <= mt_cnt_r + 1'b1;
					if (mt_valid_r)
						mt_sum_r <= mt_sum_r + flash_data_in;
					else if (mt_cnt_r == FLASH_DEPTH[FLASH_AW:0])
						mt_state_r <= MT_DONE;
				end
				MT_DONE:
					mt_state_r <= MT_IDLE;
				default:
					mt_state_r <= MT_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags: hardware set wins over a clearing read

	assign rd_diag = reg_rd_in && (reg_addr_in == OFS_DIAG);

	always_comb
	begin
		diag_set = 16'h0000;
		if (sample_tick_in)
		begin
			diag_set[15:D_ST_LO] = selftest_fail_in; // RQ8
			diag_set[D_ST_ERR] = selftest_err_in; // RQ10
			diag_set[D_OVR] = overrange_in;
			diag_set[D_COMM] = comm_fail_in;
			diag_set[D_FUPD] = flash_update_fail_in;
			diag_set[D_HIGH] = supply_high_in; // RQ6
			diag_set[D_LOW] = supply_low_in; // RQ7
		end
		if (tick_d_r)
			diag_set[D_ALM1 +: 2] = alm_act; // RQ9
		diag_set[D_FLASH] = mt_fail; // RQ2
	end

	always_comb
	begin
		diag_nxt = (diag_r & ~{16{rd_diag}}) | diag_set; // RQ3 RQ4
		// supply flags drop the moment the supply recovers
		diag_nxt[1:0] = diag_set[1:0] | (diag_r[1:0] &
			{supply_high_in, supply_low_in} & ~{2{rd_diag}}); // RQ5
		diag_nxt = diag_nxt & DIAG_MASK; // RQ10
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			diag_r <= RST_ZERO; // RQ17
		else
			diag_r <= diag_nxt;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			tick_d_r <= 1'b0;
		else
			tick_d_r <= sample_tick_in;
	end

	////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, zero elsewhere

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_r <= 16'h0000;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				OFS_DIAG: rdata_r <= diag_r;
				OFS_THR1: rdata_r <= thr_r[0];
				OFS_THR2: rdata_r <= thr_r[1];
				OFS_CNT1: rdata_r <= {8'h00, cnt_r[0]};
				OFS_CNT2: rdata_r <= {8'h00, cnt_r[1]};
				OFS_ALARM_CONTROL_REG: rdata_r <= alarm_control_reg_r;
				OFS_MISC: rdata_r <= misc_r;
				OFS_SAMPLE_PERIOD_REG: rdata_r <= sample_period_reg_r;
				default: rdata_r <= 16'h0000;
			endcase
		end
		else
			rdata_r <= 16'h0000;
	end

	assign reg_rdata_out = rdata_r;

	////////////////////////////////////////////////////////////////
	// alarm channels

	for (genvar i = 0; i < 2; i++)
	begin : g_alm
		alarm_if a_if();
		assign a_if.tick = sample_tick_in;
		always_comb a_if.enable = src_ok(src_code(i)); // RQ18
		assign a_if.roc = alarm_control_reg_r[B_ROC1 + i]; // RQ19
		always_comb a_if.data = src_pick(src_code(i));
		assign a_if.thr = thr_r[i];
		assign a_if.cnt = cnt_r[i];
		assign alm_act[i] = a_if.active;
		alarm_channel u_chan
		(
			.clock_in(clock_in),
			.rst_in(rst_in),
			.bus(a_if)
		); // RQ11
	end

	////////////////////////////////////////////////////////////////
	// alarm indicator pin

	assign alm_any = |alm_act;

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			line1_r <= 1'b0;
			line1_oe_r <= 1'b0;
			line2_r <= 1'b0;
			line2_oe_r <= 1'b0;
		end
		else
		begin
			line1_oe_r <= alarm_control_reg_r[B_OUT_EN] &&
				!alarm_control_reg_r[B_OUT_SEL]; // RQ21
			line2_oe_r <= alarm_control_reg_r[B_OUT_EN] && alarm_control_reg_r[B_OUT_SEL];
			line1_r <= alarm_control_reg_r[B_OUT_EN] && !alarm_control_reg_r[B_OUT_SEL] &&
				(alm_any == alarm_control_reg_r[B_OUT_POL]); // RQ23
			line2_r <= alarm_control_reg_r[B_OUT_EN] && alarm_control_reg_r[B_OUT_SEL] &&
				(alm_any == alarm_control_reg_r[B_OUT_POL]);
		end
	end

	assign digital_line_one_out = line1_r;
	assign digital_line_one_oe_out = line1_oe_r;
	assign digital_line_two_out = line2_r;
	assign digital_line_two_oe_out = line2_oe_r;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	sequence s_mt_start;
		!misc_r[B_MEMTEST] ##1 misc_r[B_MEMTEST];
	endsequence

	sequence s_mt_end;
		##[1:MT_MAX] !misc_r[B_MEMTEST];
	endsequence

	property p_mt_ends;
		s_mt_start |-> s_mt_end;
	endproperty
	a_mt_ends: assert property (p_mt_ends) else $error("memtest hung"); // RQ1

	property p_mt_flag;
		mt_done && (mt_sum_r != flash_checksum_in) |=> diag_r[D_FLASH];
	endproperty
	a_mt_flag: assert property (p_mt_flag) else $error("no flash flag"); // RQ2

	property p_rd_clear;
		rd_diag && (diag_set == 16'h0000) |=> (diag_r == 16'h0000);
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("not cleared"); // RQ3

	property p_rd_data;
		rd_diag |=> (reg_rdata_out == $past(diag_r));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("bad read"); // RQ3

	property p_low_set;
		sample_tick_in && supply_low_in |=> diag_r[D_LOW];
	endproperty
	a_low_set: assert property (p_low_set) else $error("low missed"); // RQ7

	property p_high_drop;
		!supply_high_in |=> !diag_r[D_HIGH];
	endproperty
	a_high_drop: assert property (p_high_drop) else $error("high stuck"); // RQ5

	property p_alm_flag;
		tick_d_r && alm_act[0] |=> diag_r[D_ALM1];
	endproperty
	a_alm_flag: assert property (p_alm_flag) else $error("alarm flag"); // RQ9

	property p_pin;
		alarm_control_reg_r[B_OUT_EN] && !alarm_control_reg_r[B_OUT_SEL] && alm_any &&
		alarm_control_reg_r[B_OUT_POL] |=> digital_line_one_oe_out &&
		digital_line_one_out;
	endproperty
	a_pin: assert property (p_pin) else $error("pin not driven"); // RQ23
endmodule

// ==== shared/diag_pkg.sv ====
/*
 Constants for the diagnostic status and alarm monitor.
 Assumes a 16-bit register port with byte addresses, one register
 every two bytes.
*/
// Summary of operation
// RQ1: memory-test bit runs a flash checksum
// RQ2: checksum result lands in status bit 6
// RQ3: reading the status register clears all flags
// RQ4: still-present conditions set again next sample
// RQ5: supply flags clear themselves when back in range
// RQ6: bit 1 set while supply too high
// RQ7: bit 0 set while supply too low
// RQ8: bits 15..10 report sensor self-test failures
// RQ9: bits 9 and 8 report alarm 2 and 1
// RQ10: bits 5..2 report other failures; bit 7 unused
// RQ11: two alarm channels, each independent
// RQ12: control picks source, filter, mode, output
// RQ13: threshold bit 15 picks greater or less
// RQ14: threshold bits 13..0 hold trigger value
// RQ15: rate interval is count times sample period
// RQ16: sample count in bits 7..0, zero means one
// RQ17: status, thresholds and counts reset to zero
// RQ18: source codes per channel, zero disables it
// RQ19: control bits 7 and 6 select rate mode
// RQ20: control bit 4 selects filtered data
// RQ21: bits 2..0 set pin enable, polarity, line
// RQ22: rate mode compares current minus older sample
// RQ23: triggered alarm sets flag and drives pin
package diag_pkg;
	localparam int ADDR_W = 8;
	localparam int SRC_W = 14;
	localparam int N_SRC = 11;
	localparam logic [7:0] OFS_DIAG = 8'h00;
	localparam logic [7:0] OFS_THR1 = 8'h02;
	localparam logic [7:0] OFS_THR2 = 8'h04;
	localparam logic [7:0] OFS_CNT1 = 8'h06;
	localparam logic [7:0] OFS_CNT2 = 8'h08;
	localparam logic [7:0] OFS_ALARM_CONTROL_REG = 8'h0a;
	localparam logic [7:0] OFS_MISC = 8'h0c;
	localparam logic [7:0] OFS_SAMPLE_PERIOD_REG = 8'h0e;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_MISC = 16'h0006;
	localparam logic [15:0] MISC_MASK = 16'h0fc7;
	localparam logic [15:0] DIAG_MASK = 16'hff7f;
	localparam int B_MEMTEST = 11;
	localparam int B_SRC1 = 8;
	localparam int B_ROC1 = 6;
	localparam int B_FILT = 4;
	localparam int B_OUT_EN = 2;
	localparam int B_OUT_POL = 1;
	localparam int B_OUT_SEL = 0;
	localparam int B_THR_GT = 15;
	localparam int D_ST_LO = 10;
	localparam int D_ALM1 = 8;
	localparam int D_FLASH = 6;
	localparam int D_ST_ERR = 5;
	localparam int D_OVR = 4;
	localparam int D_COMM = 3;
	localparam int D_FUPD = 2;
	localparam int D_HIGH = 1;
	localparam int D_LOW = 0;
	typedef enum logic [1:0] {
		MT_IDLE = 2'b00,
		MT_RUN = 2'b01,
		MT_DONE = 2'b11
	} memtest_state_type;
endpackage

// ==== shared/alarm_if.sv ====
/*
 Interface between the monitor top and one alarm channel.
 Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface alarm_if;
	logic tick;
	logic enable;
	logic roc;
	logic [13:0] data;
	logic [15:0] thr;
	logic [7:0] cnt;
	logic active;
	modport chan (input tick, enable, roc, data, thr, cnt,
		output active);
	modport ctl (output tick, enable, roc, data, thr, cnt,
		input active);
endinterface

// ==== logic/alarm_channel.sv ====
/*
 One alarm comparator: static level or rate of change.
 Assumes tick is a one-cycle pulse per sample and data is stable then.
*/
`timescale 1ns/1ps
module alarm_channel
(
	input wire logic clock_in,
	input wire logic rst_in,
	alarm_if.chan bus
);
	import diag_pkg::*;

	logic [13:0] hist [256];
	logic [7:0] wp_r;
	logic [7:0] fill_r;
	logic active_r;
	logic [7:0] n;
	logic [13:0] old;
	logic signed [14:0] t;
	logic signed [14:0] diff;

	function automatic logic hit(input logic gt, input logic signed [14:0] v,
		input logic signed [14:0] th);
		hit = gt ? (v > th) : (v < th);
	endfunction

	////////////////////////////////////////////////////////////////
	assign n = (bus.cnt == 8'h00) ? 8'h01 : bus.cnt; // RQ16
	assign old = hist[wp_r - n];
	assign t = {bus.thr[13], bus.thr[13:0]}; // RQ14
	assign diff = {bus.data[13], bus.data} - {old[13], old}; // RQ22
	assign bus.active = active_r;

	// history is plain memory, no reset needed
	always_ff @(posedge clock_in)
	begin
		if (bus.tick)
			hist[wp_r] <= bus.data;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wp_r <= 8'h00;
			fill_r <= 8'h00;
		end
		else if (bus.tick)
		begin
			wp_r <= wp_r + 8'h01;
			if (fill_r != 8'hff)
				fill_r <= fill_r + 8'h01;
		end
	end

	// interval is n ticks, each one sample period long
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			active_r <= 1'b0;
		else if (bus.tick)
		begin
			if (!bus.enable)
				active_r <= 1'b0; // RQ18
			else if (bus.roc)
				active_r <= (fill_r >= n) &&
					hit(bus.thr[B_THR_GT], diff, t); // RQ15
			else
				active_r <= hit(bus.thr[B_THR_GT],
					{bus.data[13], bus.data}, t); // RQ13
		end
	end

	////////////////////////////////////////////////////////////////
	property p_off;
		@(posedge clock_in) disable iff (rst_in)
		bus.tick && !bus.enable |=> !bus.active;
	endproperty
	a_off: assert property (p_off) else $error("disabled alarm active"); // RQ18

	property p_static;
		@(posedge clock_in) disable iff (rst_in)
		bus.tick && bus.enable && !bus.roc && bus.thr[B_THR_GT] &&
		({bus.data[13], bus.data} > t) |=> bus.active;
	endproperty
	a_static: assert property (p_static) else $error("static miss"); // RQ13

	property p_roc_wait;
		@(posedge clock_in) disable iff (rst_in)
		bus.tick && bus.enable && bus.roc && (fill_r < n) |=> !bus.active;
	endproperty
	a_roc_wait: assert property (p_roc_wait) else $error("early rate"); // RQ22
endmodule

// ==== tb/flash_model.sv ====
/*
 Behavioural flash array feeding the monitor's memory test.
 Assumes the reader wants each word one cycle after presenting its address.
*/
`timescale 1ns/1ps
module flash_model
#(
	parameter int DEPTH = 8,
	parameter int AW = 3
)
(
	input wire logic clock_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic corrupt_in,
	output logic [15:0] data_out,
	output logic [15:0] checksum_out
);
	function automatic logic [15:0] word_at(input int i);
		return 16'h9137 + 16'(i) * 16'h1234;
	endfunction
	// registered read: one cycle of latency, as the reader expects
	always_ff @(posedge clock_in)
	begin
		data_out <= word_at(int'(addr_in));
	end
	// corrupt_in skews the reference so a failing sum can be provoked
	always_comb
	begin
		checksum_out = {15'h0, corrupt_in};
		for (int i = 0; i < DEPTH; i++)
			checksum_out = checksum_out + word_at(i);
	end
endmodule

// ==== tb/diag_status_and_alarm_monitor_bench.sv ====
/*
 Self-checking bench for the diagnostic monitor.
 Assumes the register port answers reads one cycle later, no waits.
*/
`timescale 1ns/1ps
module diag_status_and_alarm_monitor_bench;
	import diag_pkg::*;
	logic clock_in, rst_in, reg_wr, reg_rd, tick, corrupt;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, rdata, fdata, fsum, sample_period_reg, v;
	logic [N_SRC-1:0][SRC_W-1:0] raw_data, filt_data;
	logic [1:0] supply;
	logic [5:0] st_fail;
	logic st_err, ovr, comm, fupd, l1, oe1, l2, oe2;
	logic [2:0] faddr;
	int bad_count, compares, n;
	diag_monitor #(.FLASH_DEPTH(8), .FLASH_AW(3)) dut (
		.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(rdata), .sample_tick_in(tick),
		.raw_data_in(raw_data), .filt_data_in(filt_data),
		.supply_high_in(supply[1]), .supply_low_in(supply[0]),
		.selftest_fail_in(st_fail), .selftest_err_in(st_err),
		.overrange_in(ovr), .comm_fail_in(comm),
		.flash_update_fail_in(fupd), .flash_addr_out(faddr),
		.flash_data_in(fdata), .flash_checksum_in(fsum),
		.sample_period_out(sample_period_reg),
		.digital_line_one_out(l1), .digital_line_one_oe_out(oe1),
		.digital_line_two_out(l2), .digital_line_two_oe_out(oe2));
	flash_model #(.DEPTH(8), .AW(3)) flash (.clock_in(clock_in),
		.addr_in(faddr), .corrupt_in(corrupt), .data_out(fdata),
		.checksum_out(fsum));
	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock_in);
		reg_rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a,
		input logic [15:0] exp);
		logic [15:0] got;
		rd(a, got);
		chk(what, exp, got);
	endtask
	// one sample tick; status and pins settle two edges later
	task automatic pulse(input logic [13:0] r, input logic [13:0] f);
		@(posedge clock_in);
		raw_data[4] <= r;
		filt_data[4] <= f;
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
	endtask
	task automatic pin1(input logic [15:0] exp);
		chk("line one oe and level", exp, {14'h0, oe1, l1});
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		bad_count++;
		final_report();
	end
	initial
	begin
		rst_in = 1'b1;
		{reg_wr, reg_rd, tick, corrupt, st_err, ovr, comm, fupd} = '0;
		{reg_addr, reg_wdata, supply, st_fail} = '0;
		raw_data = '0;
		filt_data = '0;
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		rchk("status reset", OFS_DIAG, 16'h0000);
		rchk("thr1 reset", OFS_THR1, 16'h0000);
		rchk("thr2 reset", OFS_THR2, 16'h0000);
		rchk("cnt1 reset", OFS_CNT1, 16'h0000);
		rchk("cnt2 reset", OFS_CNT2, 16'h0000);
		rchk("misc reset", OFS_MISC, 16'h0006);
		rchk("unmapped", 8'h40, 16'h0000);
		wr(OFS_THR1, 16'h8123);
		rchk("thr1", OFS_THR1, 16'h8123);
		wr(OFS_CNT2, 16'hff05);
		rchk("cnt2 upper byte", OFS_CNT2, 16'h0005);
		// sticky flags, cleared by read, re-set while still present
		@(posedge clock_in);
		st_fail <= 6'h2a;
		{st_err, ovr, comm, fupd} <= 4'hf;
		pulse(14'h0, 14'h0);
		@(posedge clock_in);
		st_fail <= 6'h00;
		{st_err, comm, fupd} <= 3'h0;
		rchk("flags", OFS_DIAG, 16'ha83c);
		pulse(14'h0, 14'h0);
		rchk("held flag", OFS_DIAG, 16'h0010);
		@(posedge clock_in);
		ovr <= 1'b0;
		pulse(14'h0, 14'h0);
		rchk("cleared", OFS_DIAG, 16'h0000);
		// supply flags drop by themselves once back in range
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock_in);
			supply[i] <= 1'b1;
			pulse(14'h0, 14'h0);
			rchk("supply flag", OFS_DIAG, 16'h0001 << i);
			pulse(14'h0, 14'h0);
			@(posedge clock_in);
			supply[i] <= 1'b0;
			repeat (2) @(posedge clock_in);
			rchk("supply back", OFS_DIAG, 16'h0000);
		end
		// memory test: pass, then a skewed reference
		for (int p = 0; p < 2; p++)
		begin
			@(posedge clock_in);
			corrupt <= p[0];
			wr(OFS_MISC, 16'h0800);
			n = 0;
			do
			begin
				rd(OFS_MISC, v);
				n++;
			end
			while (v[11] === 1'b1 && n < 40);
			chk("memtest busy", 16'h0000, v & 16'h0800);
			rchk("memtest flag", OFS_DIAG, p[0] ? 16'h0040 : 16'h0000);
		end
		// static alarm one on source code 5
		wr(OFS_ALARM_CONTROL_REG, 16'h0506);
		wr(OFS_THR1, 16'h8064);
		pulse(14'd200, 14'd0);
		pin1(16'h0003);
		rchk("alarm1 flag", OFS_DIAG, 16'h0100);
		pulse(14'd50, 14'd0);
		pin1(16'h0002);
		wr(OFS_THR1, 16'h0064);
		pulse(14'd50, 14'd0);
		pin1(16'h0003);
		wr(OFS_ALARM_CONTROL_REG, 16'h0516);
		wr(OFS_THR1, 16'h8064);
		pulse(14'd50, 14'd200);
		pin1(16'h0003);
		pulse(14'd200, 14'd50);
		pin1(16'h0002);
		rchk("alarm1 sticky", OFS_DIAG, 16'h0100);
		// alarm two alone, active low on line two
		wr(OFS_ALARM_CONTROL_REG, 16'h5005);
		wr(OFS_THR2, 16'h8064);
		pulse(14'd200, 14'd0);
		chk("line two", 16'h0002, {14'h0, oe2, l2});
		pin1(16'h0000);
		rchk("alarm2 flag", OFS_DIAG, 16'h0200);
		// source code beyond the table disables the channel
		wr(OFS_ALARM_CONTROL_REG, 16'h0c06);
		pulse(14'd200, 14'd0);
		pin1(16'h0002);
		// rate of change over two samples, then count zero as one
		wr(OFS_ALARM_CONTROL_REG, 16'h0546);
		wr(OFS_THR1, 16'h800a);
		wr(OFS_CNT1, 16'h0002);
		repeat (3) pulse(14'd0, 14'd0);
		pin1(16'h0002);
		pulse(14'd20, 14'd0);
		pin1(16'h0003);
		pulse(14'd20, 14'd0);
		pin1(16'h0003);
		pulse(14'd20, 14'd0);
		pin1(16'h0002);
		wr(OFS_CNT1, 16'h0000);
		pulse(14'd50, 14'd0);
		pin1(16'h0003);
		pulse(14'd50, 14'd0);
		pin1(16'h0002);
		// alarm two in rate mode, line two active high
		wr(OFS_ALARM_CONTROL_REG, 16'h5087);
		wr(OFS_THR2, 16'h800a);
		wr(OFS_CNT2, 16'h0001);
		pulse(14'd0, 14'd0);
		chk("line two rate", 16'h0002, {14'h0, oe2, l2});
		pulse(14'd20, 14'd0);
		chk("line two rate", 16'h0003, {14'h0, oe2, l2});
		pulse(14'd20, 14'd0);
		chk("line two rate", 16'h0002, {14'h0, oe2, l2});
		wr(OFS_SAMPLE_PERIOD_REG, 16'h0001);
		rchk("sample period", OFS_SAMPLE_PERIOD_REG, 16'h0001);
		chk("sample period out", 16'h0001, sample_period_reg);
		// reset mid-run: rate mode waits until n samples are held
		@(posedge clock_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		rchk("cnt1 after reset", OFS_CNT1, 16'h0000);
		pin1(16'h0000);
		wr(OFS_ALARM_CONTROL_REG, 16'h0546);
		wr(OFS_THR1, 16'h800a);
		wr(OFS_CNT1, 16'h0003);
		repeat (3)
		begin
			pulse(14'd20, 14'd0);
			pin1(16'h0002);
		end
		pulse(14'd40, 14'd0);
		pin1(16'h0003);
		final_report();
	end
endmodule
